// ### gpef_ports.sv
// Purpose: port E, F and G data latches, direction and pin muxing
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   data latches carry no reset; pins are in/out/enable triples
// Summary of operation
// - direction one drives pin, zero tristates
// - reset clears port E direction
// - reset clears port F direction
// - port F latches untouched by reset
// - port G latches untouched by reset
// - port E read returns latch when output
// - port F read returns latch when output
// - input bits read sampled pin level
// - data writes always update latches
// - E7 is SPI clock when SPI on
// - E7..E5 general I/O while SPI off
// - E4 general unless SPI slave or fault
// - slave select ignores direction bit
// - E3,E2 timer A ch1,ch0 when selected
// - E1,E0 owned by serial if enabled
// - owned E pins: direction selects read only
// - F3..F0 timer A ch5..ch2 when selected
// - F5,F4 timer B ch1,ch0 when selected
// - owned F pins: direction selects read only
// - port G latch per pin with direction
// - port G read latch or pin level
// - reset clears port G direction
// - keypad enable overrides G drive; direction still selects read
`timescale 1ns/100ps
`default_nettype none
module gpef_ports (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  port_e_in,
  output logic      [7:0]  port_e_out,
  output logic      [7:0]  port_e_oe,
  input  wire logic [6:0]  port_f_in,
  output logic      [6:0]  port_f_out,
  output logic      [6:0]  port_f_oe,
  input  wire logic [2:0]  port_g_in,
  output logic      [2:0]  port_g_out,
  output logic      [2:0]  port_g_oe,
  input  wire logic [7:0]  periph_e_out,
  input  wire logic [7:0]  periph_e_oe,
  input  wire logic [6:0]  periph_f_out,
  input  wire logic [6:0]  periph_f_oe,
  output logic             spi_enable_bit,
  output logic             spi_master_select,
  output logic             mode_fault_enable,
  output logic             serial_if_enable,
  output logic      [7:0]  edge_level_select,
  output logic      [2:0]  keypad_irq_enable,
  output logic      [7:0]  port_e_owned,
  output logic      [6:0]  port_f_owned
);
  localparam int unsigned EW = gpef_pkg::E_WIDTH;
  localparam int unsigned FW = gpef_pkg::F_WIDTH;
  localparam int unsigned GW = gpef_pkg::G_WIDTH;
  localparam int unsigned SW = EW + FW + GW;

  typedef struct packed {
    logic          ap_valid;
    logic          ap_write;
    logic [7:0]    ap_index;
    logic [EW-1:0] port_e_direction;
    logic [FW-1:0] port_f_direction;
    logic [GW-1:0] port_g_direction;
    logic [3:0]    periph_ctrl;
    logic [7:0]    timer_own;
    logic [GW-1:0] keypad_en;
    logic [31:0]   rdata;
  } gpef_ctl_s;

  typedef struct packed {
    logic [EW-1:0] port_e_data_latch;
    logic [FW-1:0] port_f_data_latch;
    logic [GW-1:0] port_g_data_latch;
  } gpef_lat_s;

  gpef_ctl_s st;
  gpef_ctl_s next_st;
  gpef_lat_s lat;
  gpef_lat_s next_lat;

  logic [EW-1:0] pin_e;
  logic [FW-1:0] pin_f;
  logic [GW-1:0] pin_g;
  logic [EW-1:0] rd_e;
  logic [FW-1:0] rd_f;
  logic [GW-1:0] rd_g;
  logic          take;
  logic          e4_general;

  gpef_sync_if #(.W(SW)) sif ();
  assign sif.raw = {port_e_in, port_f_in, port_g_in};

  gpef_sync #(.W(SW)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (sif)
  );

  assign pin_e = sif.sampled[SW-1 -: EW];
  assign pin_f = sif.sampled[FW+GW-1 -: FW];
  assign pin_g = sif.sampled[GW-1:0];

  assign spi_enable_bit    = st.periph_ctrl[gpef_pkg::SPI_EN_POS];
  assign spi_master_select = st.periph_ctrl[gpef_pkg::SPI_MSTR_POS];
  assign mode_fault_enable = st.periph_ctrl[gpef_pkg::MODF_EN_POS];
  assign serial_if_enable  = st.periph_ctrl[gpef_pkg::SCI_EN_POS];
  assign edge_level_select = st.timer_own;
  assign keypad_irq_enable = st.keypad_en;

  assign e4_general = !spi_enable_bit
                    || (spi_master_select && !mode_fault_enable);

  always_comb begin
    port_e_owned[7] = spi_enable_bit;
    port_e_owned[6] = spi_enable_bit;
    port_e_owned[5] = spi_enable_bit;
    port_e_owned[4] = !e4_general;
    port_e_owned[3] = st.timer_own[gpef_pkg::TA_POS + 1];
    port_e_owned[2] = st.timer_own[gpef_pkg::TA_POS];
    port_e_owned[1] = serial_if_enable;
    port_e_owned[0] = serial_if_enable;
    port_f_owned[3:0] = st.timer_own[gpef_pkg::TA_POS + 2 +: 4];
    port_f_owned[5:4] = st.timer_own[gpef_pkg::TB_POS +: 2];
    port_f_owned[6]   = 1'b0;
  end

  assign port_e_out = (port_e_owned & periph_e_out)
                    | (~port_e_owned & lat.port_e_data_latch);
  assign port_e_oe  = (port_e_owned & periph_e_oe)
                    | (~port_e_owned & st.port_e_direction);
  assign port_f_out = (port_f_owned & periph_f_out)
                    | (~port_f_owned & lat.port_f_data_latch);
  assign port_f_oe  = (port_f_owned & periph_f_oe)
                    | (~port_f_owned & st.port_f_direction);
  assign port_g_out = lat.port_g_data_latch;
  assign port_g_oe  = st.port_g_direction & ~st.keypad_en;

  assign rd_e = (st.port_e_direction & lat.port_e_data_latch)
              | (~st.port_e_direction & pin_e);
  assign rd_f = (st.port_f_direction & lat.port_f_data_latch)
              | (~st.port_f_direction & pin_f);
  assign rd_g = (st.port_g_direction & lat.port_g_data_latch)
              | (~st.port_g_direction & pin_g);

  assign take = hsel && hready
             && (htrans == gpef_pkg::HTRANS_NONSEQ
              || htrans == gpef_pkg::HTRANS_SEQ);

  always_comb begin
    next_st  = st;
    next_lat = lat;
    next_st.ap_valid = take;
    next_st.ap_write = hwrite;
    next_st.ap_index = haddr[9:2];
    if (st.ap_valid && st.ap_write) begin
      case (st.ap_index)
        gpef_pkg::IDX_PORT_E_DATA: begin
          next_lat.port_e_data_latch = hwdata[EW-1:0];
        end
        gpef_pkg::IDX_PORT_F_DATA: begin
          next_lat.port_f_data_latch = hwdata[FW-1:0];
        end
        gpef_pkg::IDX_PORT_G_DATA: begin
          next_lat.port_g_data_latch = hwdata[GW-1:0];
        end
        gpef_pkg::IDX_PORT_E_DIR: begin
          next_st.port_e_direction = hwdata[EW-1:0];
        end
        gpef_pkg::IDX_PORT_F_DIR: begin
          next_st.port_f_direction = hwdata[FW-1:0];
        end
        gpef_pkg::IDX_PORT_G_DIR: begin
          next_st.port_g_direction = hwdata[GW-1:0];
        end
        gpef_pkg::IDX_PERIPH_CTRL: begin
          next_st.periph_ctrl = hwdata[3:0];
        end
        gpef_pkg::IDX_TIMER_OWN: begin
          next_st.timer_own = hwdata[7:0];
        end
        gpef_pkg::IDX_KEYPAD_EN: begin
          next_st.keypad_en = hwdata[GW-1:0];
        end
        default: begin
          next_st.rdata = st.rdata;
        end
      endcase
    end
    next_st.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      case (haddr[9:2])
        gpef_pkg::IDX_PORT_E_DATA: next_st.rdata[EW-1:0] = rd_e;
        gpef_pkg::IDX_PORT_F_DATA: next_st.rdata[FW-1:0] = rd_f;
        gpef_pkg::IDX_PORT_G_DATA: next_st.rdata[GW-1:0] = rd_g;
        gpef_pkg::IDX_PORT_E_DIR:
          next_st.rdata[EW-1:0] = next_st.port_e_direction;
        gpef_pkg::IDX_PORT_F_DIR:
          next_st.rdata[FW-1:0] = next_st.port_f_direction;
        gpef_pkg::IDX_PORT_G_DIR:
          next_st.rdata[GW-1:0] = next_st.port_g_direction;
        gpef_pkg::IDX_PERIPH_CTRL:
          next_st.rdata[3:0] = next_st.periph_ctrl;
        gpef_pkg::IDX_TIMER_OWN:
          next_st.rdata[7:0] = next_st.timer_own;
        gpef_pkg::IDX_KEYPAD_EN:
          next_st.rdata[GW-1:0] = next_st.keypad_en;
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.ap_valid         <= 1'b0;
      st.ap_write         <= 1'b0;
      st.ap_index         <= 8'h00;
      st.port_e_direction <= gpef_pkg::DIR_RESET[EW-1:0];
      st.port_f_direction <= gpef_pkg::DIR_RESET[FW-1:0];
      st.port_g_direction <= gpef_pkg::DIR_RESET[GW-1:0];
      st.periph_ctrl      <= gpef_pkg::CTRL_RESET[3:0];
      st.timer_own        <= gpef_pkg::CTRL_RESET;
      st.keypad_en        <= gpef_pkg::CTRL_RESET[GW-1:0];
      st.rdata            <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge hclk) begin
    lat <= next_lat;
  end

  // zero wait state slave, always OKAY
  assign hrdata    = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  sequence s_dir_write_e;
    st.ap_valid && st.ap_write && st.ap_index == gpef_pkg::IDX_PORT_E_DIR;
  endsequence

  AST_DIR_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_dir_write_e |=> (port_e_oe & ~port_e_owned)
                      == ($past(hwdata[7:0]) & ~port_e_owned))
    else $error("port E enable does not follow direction");
  AST_RST_E: assert property (@(posedge hclk)
    $rose(hresetn) |-> st.port_e_direction == 8'h00)
    else $error("port E direction not cleared");
  AST_RST_F: assert property (@(posedge hclk)
    $rose(hresetn) |-> st.port_f_direction == 7'h00)
    else $error("port F direction not cleared");
  AST_RST_G: assert property (@(posedge hclk)
    $rose(hresetn) |-> port_g_oe == 3'h0)
    else $error("port G direction not cleared");
  AST_READ_E: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr[9:2] == gpef_pkg::IDX_PORT_E_DATA
      |=> (hrdata[7:0] & $past(st.port_e_direction))
          == ($past(lat.port_e_data_latch) & $past(st.port_e_direction)))
    else $error("port E read missed latch");
  AST_READ_PIN_F: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr[9:2] == gpef_pkg::IDX_PORT_F_DATA
      |=> (hrdata[6:0] & ~$past(st.port_f_direction))
          == ($past(pin_f) & ~$past(st.port_f_direction)))
    else $error("port F read missed pin level");
  AST_WRITE_F: assert property (@(posedge hclk) disable iff (!hresetn)
    st.ap_valid && st.ap_write && st.ap_index == gpef_pkg::IDX_PORT_F_DATA
      |=> lat.port_f_data_latch == $past(hwdata[6:0]))
    else $error("port F latch not written");
  AST_SPI_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    !spi_enable_bit |-> port_e_oe[7:5] == st.port_e_direction[7:5])
    else $error("SPI pins not general while disabled");
  AST_SS_SLAVE: assert property (@(posedge hclk) disable iff (!hresetn)
    spi_enable_bit && !spi_master_select |-> port_e_oe[4] == periph_e_oe[4])
    else $error("slave select steered by direction");
  AST_KEYPAD: assert property (@(posedge hclk) disable iff (!hresetn)
    (keypad_irq_enable & port_g_oe) == 3'h0)
    else $error("keypad pin still driven");
  // a pin taken by a peripheral must follow that peripheral alone
  AST_SPI_CLK: assert property (@(posedge hclk) disable iff (!hresetn)
    spi_enable_bit |-> port_e_oe[7] == periph_e_oe[7]
                       && port_e_out[7] == periph_e_out[7])
    else $error("SPI clock pin not handed to SPI");
  AST_TIMER_E: assert property (@(posedge hclk) disable iff (!hresetn)
    port_e_owned[3:2] == edge_level_select[1:0])
    else $error("timer A pins on port E not owned as selected");
  AST_SERIAL_E: assert property (@(posedge hclk) disable iff (!hresetn)
    serial_if_enable |-> port_e_oe[1:0] == periph_e_oe[1:0])
    else $error("serial pins still steered by direction");
  AST_TIMER_F: assert property (@(posedge hclk) disable iff (!hresetn)
    ((port_f_oe ^ periph_f_oe) & port_f_owned) == 7'h00)
    else $error("timer pin on port F steered by direction");
  AST_READ_F: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr[9:2] == gpef_pkg::IDX_PORT_F_DATA
      |=> (hrdata[6:0] & $past(st.port_f_direction))
          == ($past(lat.port_f_data_latch) & $past(st.port_f_direction)))
    else $error("port F read missed latch");
  AST_READ_G: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr[9:2] == gpef_pkg::IDX_PORT_G_DATA
      |=> hrdata[2:0]
          == (($past(st.port_g_direction) & $past(lat.port_g_data_latch))
           | (~$past(st.port_g_direction) & $past(pin_g))))
    else $error("port G read mixed latch and pin wrongly");
  AST_UNUSED_F: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr[9:2] == gpef_pkg::IDX_PORT_F_DATA
      |=> hrdata[31:7] == 25'h0)
    else $error("unused port F read bits not zero");
endmodule : gpef_ports
`default_nettype wire

// ### gpef_pkg.sv
// Purpose: constants for the port E/F/G general-purpose I/O block
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   printed offsets are word indices; byte address is index * 4
package gpef_pkg;
  localparam int unsigned E_WIDTH = 8;
  localparam int unsigned F_WIDTH = 7;
  localparam int unsigned G_WIDTH = 3;
  // register indices; byte address = index * 4
  localparam logic [7:0] IDX_PORT_E_DATA = 8'h08;
  localparam logic [7:0] IDX_PORT_F_DATA = 8'h09;
  localparam logic [7:0] IDX_PORT_G_DATA = 8'h0a;
  localparam logic [7:0] IDX_PORT_E_DIR  = 8'h0c;
  localparam logic [7:0] IDX_PORT_F_DIR  = 8'h0d;
  localparam logic [7:0] IDX_PORT_G_DIR  = 8'h0e;
  localparam logic [7:0] IDX_PERIPH_CTRL = 8'h10;
  localparam logic [7:0] IDX_TIMER_OWN   = 8'h11;
  localparam logic [7:0] IDX_KEYPAD_EN   = 8'h12;
  // peripheral control field positions
  localparam int unsigned SPI_EN_POS     = 0;
  localparam int unsigned SPI_MSTR_POS   = 1;
  localparam int unsigned MODF_EN_POS    = 2;
  localparam int unsigned SCI_EN_POS     = 3;
  // timer ownership field positions: timer A ch0..5, timer B ch0..1
  localparam int unsigned TA_POS         = 0;
  localparam int unsigned TB_POS         = 6;
  localparam logic [7:0] DIR_RESET       = 8'h00;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0] HTRANS_SEQ      = 2'h3;
endpackage : gpef_pkg

// ### gpef_sync_if.sv
// Purpose: carries raw pin levels into the synchroniser and sampled back
// Assumes: single clock domain on the sampled side
// Notes:   raw levels are asynchronous to hclk
`timescale 1ns/100ps
`default_nettype none
interface gpef_sync_if #(parameter int unsigned W = 18);
  logic [W-1:0] raw;
  logic [W-1:0] sampled;
  modport sink   (input raw, output sampled);
  modport source (output raw, input sampled);
endinterface : gpef_sync_if
`default_nettype wire

// ### gpef_sync.sv
// Purpose: two-stage synchroniser for all port pin inputs
// Assumes: hclk domain, asynchronous active-low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module gpef_sync #(
  parameter int unsigned W = 18
) (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  gpef_sync_if.sink  sif
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } gpef_sync_s;

  gpef_sync_s st;
  gpef_sync_s next_st;

  always_comb begin
    next_st        = st;
    next_st.meta   = sif.raw;
    next_st.stable = st.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sif.sampled = st.stable;
endmodule : gpef_sync
`default_nettype wire

// ### gpef_pin_load.sv
// Purpose: outside circuitry seen by one port's pins
// Assumes: no pull resistors; the outside level is chosen per test
// Notes:   a pin the block releases follows the outside driver only
`timescale 1ns/100ps
`default_nettype none
module gpef_pin_load #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] level
);
  assign level = (oe & out) | (~oe & ext);
endmodule : gpef_pin_load
`default_nettype wire

// ### testbench.sv
// Purpose: self-checking bench for the port E/F/G block
// Assumes: zero-wait slave, byte address is index times four
// Notes:   latches are written before any data read, as they power up X
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  e_out, e_oe, e_in, pe_out, pe_oe, ext_e, e_own, els;
  logic [6:0]  f_out, f_oe, f_in, pf_out, pf_oe, ext_f, f_own;
  logic [2:0]  g_out, g_oe, g_in, ext_g, kb;
  logic        spi, mst, modf, sci;
  int          n_errors, tests_run;
  int          lat_e, lat_f, lat_g, dir_e, dir_f, dir_g, ctl, own, kbe;
  int          oe_x[3], out_x[3], pin_x[3];
  logic [7:0]  tab[6] = '{gpef_pkg::IDX_PORT_E_DATA,
    gpef_pkg::IDX_PORT_F_DATA, gpef_pkg::IDX_PORT_G_DATA,
    gpef_pkg::IDX_PORT_E_DIR, gpef_pkg::IDX_PORT_F_DIR,
    gpef_pkg::IDX_PORT_G_DIR};

  gpef_ports dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .port_e_in(e_in),
    .port_e_out(e_out), .port_e_oe(e_oe), .port_f_in(f_in),
    .port_f_out(f_out), .port_f_oe(f_oe), .port_g_in(g_in),
    .port_g_out(g_out), .port_g_oe(g_oe), .periph_e_out(pe_out),
    .periph_e_oe(pe_oe), .periph_f_out(pf_out), .periph_f_oe(pf_oe),
    .spi_enable_bit(spi), .spi_master_select(mst),
    .mode_fault_enable(modf), .serial_if_enable(sci),
    .edge_level_select(els), .keypad_irq_enable(kb),
    .port_e_owned(e_own), .port_f_owned(f_own));
  gpef_pin_load #(.W(8)) load_e (.out(e_out), .oe(e_oe), .ext(ext_e),
    .level(e_in));
  gpef_pin_load #(.W(7)) load_f (.out(f_out), .oe(f_oe), .ext(ext_f),
    .level(f_in));
  gpef_pin_load #(.W(3)) load_g (.out(g_out), .oe(g_oe), .ext(ext_g),
    .level(g_in));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected read at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected pin at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_pin

  // one single transfer; address held until hready is seen high
  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= gpef_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    haddr  <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] idx, input int d);
    ahb(1'b1, idx, d, rd);
    case (idx)
      gpef_pkg::IDX_PORT_E_DATA: lat_e = d & 'hff;
      gpef_pkg::IDX_PORT_F_DATA: lat_f = d & 'h7f;
      gpef_pkg::IDX_PORT_G_DATA: lat_g = d & 'h7;
      gpef_pkg::IDX_PORT_E_DIR:  dir_e = d & 'hff;
      gpef_pkg::IDX_PORT_F_DIR:  dir_f = d & 'h7f;
      gpef_pkg::IDX_PORT_G_DIR:  dir_g = d & 'h7;
      gpef_pkg::IDX_PERIPH_CTRL: ctl = d & 'hf;
      gpef_pkg::IDX_TIMER_OWN:   own = d & 'hff;
      gpef_pkg::IDX_KEYPAD_EN:   kbe = d & 'h7;
      default: ;
    endcase
  endtask : wr

  function automatic int own_e();
    own_e = {{3{ctl[0]}}, ctl[0] & ~(ctl[1] & ~ctl[2]), own[1:0],
             {2{ctl[3]}}};
  endfunction : own_e

  function automatic int own_f();
    own_f = {own[7:6], own[5:2]};
  endfunction : own_f

  task automatic model();
    oe_x[0]  = ((own_e() & pe_oe) | (~own_e() & dir_e)) & 'hff;
    out_x[0] = ((own_e() & pe_out) | (~own_e() & lat_e)) & 'hff;
    oe_x[1]  = ((own_f() & pf_oe) | (~own_f() & dir_f)) & 'h7f;
    out_x[1] = ((own_f() & pf_out) | (~own_f() & lat_f)) & 'h7f;
    oe_x[2]  = dir_g & ~kbe & 'h7;
    out_x[2] = lat_g;
    pin_x[0] = (oe_x[0] & out_x[0]) | (~oe_x[0] & ext_e);
    pin_x[1] = (oe_x[1] & out_x[1]) | (~oe_x[1] & ext_f);
    pin_x[2] = (oe_x[2] & out_x[2]) | (~oe_x[2] & ext_g);
  endtask : model

  function automatic int exp_rd(input logic [7:0] idx);
    case (idx)
      gpef_pkg::IDX_PORT_E_DATA:
        exp_rd = (dir_e & lat_e) | (~dir_e & pin_x[0]);
      gpef_pkg::IDX_PORT_F_DATA:
        exp_rd = (dir_f & lat_f) | (~dir_f & pin_x[1]);
      gpef_pkg::IDX_PORT_G_DATA:
        exp_rd = (dir_g & lat_g) | (~dir_g & pin_x[2]);
      gpef_pkg::IDX_PORT_E_DIR:  exp_rd = dir_e;
      gpef_pkg::IDX_PORT_F_DIR:  exp_rd = dir_f;
      gpef_pkg::IDX_PORT_G_DIR:  exp_rd = dir_g;
      gpef_pkg::IDX_PERIPH_CTRL: exp_rd = ctl;
      gpef_pkg::IDX_TIMER_OWN:   exp_rd = own;
      gpef_pkg::IDX_KEYPAD_EN:   exp_rd = kbe;
      default:                   exp_rd = 0;
    endcase
  endfunction : exp_rd

  task automatic rdchk(input logic [7:0] idx);
    ahb(1'b0, idx, 32'h0, rd);
    model();
    chk_reg(rd, exp_rd(idx));
    chk_reg({31'h0, hresp}, 32'h0);
  endtask : rdchk

  task automatic pins();
    model();
    chk_pin(e_oe, oe_x[0]);
    chk_pin(e_out & e_oe, out_x[0] & oe_x[0]);
    chk_pin(f_oe, oe_x[1]);
    chk_pin(f_out & f_oe, out_x[1] & oe_x[1]);
    chk_pin(g_oe, oe_x[2]);
    chk_pin(g_out & g_oe, out_x[2] & oe_x[2]);
    chk_pin(e_own, own_e());
    chk_pin(f_own, own_f());
    chk_pin({els, kb, sci, modf, mst, spi},
            {own[7:0], kbe[2:0], ctl[3:0]});
  endtask : pins

  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {pe_out, pe_oe, pf_out, pf_oe, ext_e, ext_f, ext_g} = '0;
    void'($urandom(32'h4883));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    pins();
    for (int k = 3; k < 6; k++) rdchk(tab[k]);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      ext_e  <= 8'($urandom);
      ext_f  <= 7'($urandom);
      ext_g  <= 3'($urandom);
      pe_out <= 8'($urandom);
      pe_oe  <= 8'($urandom);
      pf_out <= 7'($urandom);
      pf_oe  <= 7'($urandom);
      for (int k = 0; k < 6; k++) wr(tab[k], $urandom);
      wr(gpef_pkg::IDX_PERIPH_CTRL, (i < 16) ? i : $urandom);
      wr(gpef_pkg::IDX_TIMER_OWN, $urandom);
      wr(gpef_pkg::IDX_KEYPAD_EN, $urandom);
      repeat (3) @(posedge hclk);
      pins();
      for (int k = 0; k < 6; k++) rdchk(tab[k]);
      rdchk(gpef_pkg::IDX_PERIPH_CTRL);
      rdchk(gpef_pkg::IDX_TIMER_OWN);
      rdchk(gpef_pkg::IDX_KEYPAD_EN);
    end
    $display("test random ports done");
    wr(tab[4], 32'hffffffff);
    wr(tab[5], 32'hffffffff);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    {dir_e, dir_f, dir_g, ctl, own, kbe} = '0;
    pins();
    for (int k = 3; k < 6; k++) rdchk(tab[k]);
    for (int k = 3; k < 6; k++) wr(tab[k], 32'hffffffff);
    for (int k = 0; k < 3; k++) rdchk(tab[k]);
    $display("test latch retention done");
    wr(8'h3f, $urandom);
    rdchk(8'h3f);
    $display("test unmapped done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
